// *** common/arop_pkg.sv ***
// Constants and types for the converter result output port
package arop_pkg;
   localparam int RESULT_W = 15;
   localparam int BYTE_W = 8;
   localparam int BUS_W = 16;
   localparam logic [15:0] RESULT_RST = 16'h0000;
   localparam int LOAD_PULSE_NS = 100;
   localparam int CLK_NS = 10;
   localparam int LOAD_PULSE_CYC = (LOAD_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int STROBE_NS = 100;
   localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] LOAD_PULSE_CNT = 4'(LOAD_PULSE_CYC);
   localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
   typedef enum logic [2:0] {
      AROP_IDLE,
      AROP_WAIT_UP,
      AROP_LOAD_UP,
      AROP_WAIT_LO,
      AROP_LOAD_LO
   } arop_hs_state_t;
endpackage : arop_pkg

// *** core/arop_pulse.sv ***
// Low-going pulse generator of fixed length
`timescale 1ns/100ps
module arop_pulse
   import arop_pkg::*;
#(
   parameter logic [3:0] LEN = 4'h1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic fire,
   output logic pulse_n,
   output logic busy
);
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic pulse_n_q;
   logic pulse_n_d;

   always_comb begin
      cnt_d = cnt_q;
      if (fire && cnt_q == 4'h0) begin
         cnt_d = LEN;
      end else if (cnt_q != 4'h0) begin
         cnt_d = cnt_q - 4'h1;
      end
      pulse_n_d = !(cnt_d != 4'h0);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= 4'h0;
         pulse_n_q <= 1'b1;
      end else begin
         cnt_q <= cnt_d;
         pulse_n_q <= pulse_n_d;
      end
   end

   assign pulse_n = pulse_n_q;
   assign busy = cnt_q != 4'h0;
endmodule : arop_pulse

// *** core/arop_port.sv ***
// Result output port: bus read mode and byte handshake mode
`timescale 1ns/100ps
module arop_port
   import arop_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [14:0] conv_result,
   input wire logic conv_sign,
   input wire logic conv_done,
   input wire logic chip_select_n,
   input wire logic upper_byte_output_en_n,
   input wire logic lower_byte_output_en_n,
   input wire logic output_protocol_select,
   input wire logic peer_ready_request,
   output logic [15:0] data_out,
   output logic [15:0] data_oe,
   output logic result_update_strobe_n,
   output logic load_pulse_n,
   output logic upper_byte_flag_n,
   output logic lower_byte_flag_n,
   output logic handshake_active
);
   arop_hs_state_t st_q, st_d;
   logic [15:0] latch_q, latch_d;
   logic hs_q, hs_d;
   logic pend_q, pend_d;
   logic [15:0] dout_q, dout_d;
   logic [15:0] oe_q, oe_d;
   logic uflag_q, uflag_d;
   logic lflag_q, lflag_d;
   logic sel_q, sel_d;
   logic load_fire;
   logic load_busy;
   logic strobe_fire;
   logic lat_upd;

   // Sign sits on bit 15 beside the upper seven magnitude bits
   function automatic logic [15:0] byte_mask(input logic up, input logic lo);
      byte_mask = {{BYTE_W{up}}, {BYTE_W{lo}}};
   endfunction : byte_mask

   always_comb begin
      st_d = st_q;
      latch_d = latch_q;
      hs_d = hs_q;
      pend_d = pend_q;
      uflag_d = uflag_q;
      lflag_d = lflag_q;
      sel_d = output_protocol_select;
      load_fire = 1'b0;
      lat_upd = 1'b0;
      // Frozen while the flop is set so both bytes match
      if (conv_done && !hs_q) begin
         latch_d = {conv_sign, conv_result};
         lat_upd = 1'b1;
      end
      // Held-high select re-arms after every conversion done outside a handshake
      if (conv_done && !hs_q && output_protocol_select) begin
         pend_d = 1'b1;
      end
      unique case (st_q)
         AROP_IDLE: begin
            // Rising select, flop clear; tied high waits
            if (output_protocol_select && !sel_q && !conv_done) begin
               hs_d = 1'b1;
               pend_d = 1'b0;
               st_d = AROP_WAIT_UP;
            end else if (pend_q) begin
               hs_d = 1'b1;
               pend_d = 1'b0;
               st_d = AROP_WAIT_UP;
            end
         end
         AROP_WAIT_UP: begin
            if (peer_ready_request) begin
               uflag_d = 1'b0;
               load_fire = 1'b1;
               st_d = AROP_LOAD_UP;
            end
         end
         AROP_LOAD_UP: begin
            // Wait for the pulse to end before polling again
            if (!load_busy && !load_fire) begin
               st_d = AROP_WAIT_LO;
            end
         end
         AROP_WAIT_LO: begin
            // Peer drops request after a load, so no double send
            if (peer_ready_request) begin
               uflag_d = 1'b1;
               lflag_d = 1'b0;
               load_fire = 1'b1;
               st_d = AROP_LOAD_LO;
            end
         end
         AROP_LOAD_LO: begin
            if (!load_busy) begin
               lflag_d = 1'b1;
               hs_d = 1'b0;
               st_d = AROP_IDLE;
            end
         end
      endcase
   end

   always_comb begin
      dout_d = latch_q;
      oe_d = 16'h0000;
      if (hs_q) begin
         // Next flags, so the byte stands with the load pulse
         if (!uflag_d) begin
            dout_d = {latch_q[15:8], latch_q[15:8]};
            oe_d = byte_mask(1'b1, 1'b1);
         end else if (!lflag_d) begin
            dout_d = {latch_q[7:0], latch_q[7:0]};
            oe_d = byte_mask(1'b1, 1'b1);
         end
      end else if (!chip_select_n) begin
         // Each byte enable independent; both give 16 bits
         oe_d = byte_mask(!upper_byte_output_en_n, !lower_byte_output_en_n);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= AROP_IDLE;
         latch_q <= RESULT_RST;
         hs_q <= 1'b0;
         pend_q <= 1'b0;
         dout_q <= 16'h0000;
         oe_q <= 16'h0000;
         uflag_q <= 1'b1;
         lflag_q <= 1'b1;
         sel_q <= 1'b0;
      end else begin
         st_q <= st_d;
         latch_q <= latch_d;
         hs_q <= hs_d;
         pend_q <= pend_d;
         dout_q <= dout_d;
         oe_q <= oe_d;
         uflag_q <= uflag_d;
         lflag_q <= lflag_d;
         sel_q <= sel_d;
      end
   end

   assign strobe_fire = lat_upd;

   arop_pulse #(.LEN(LOAD_PULSE_CNT)) u_load (
      .clk(clk),
      .rst(rst),
      .fire(load_fire),
      .pulse_n(load_pulse_n),
      .busy(load_busy)
   );

   // Rising edge after the latch changes clocks an external port
   arop_pulse #(.LEN(STROBE_CNT)) u_strobe (
      .clk(clk),
      .rst(rst),
      .fire(strobe_fire),
      .pulse_n(result_update_strobe_n),
      .busy()
   );

   assign data_out = dout_q;
   assign data_oe = oe_q;
   assign upper_byte_flag_n = uflag_q;
   assign lower_byte_flag_n = lflag_q;
   assign handshake_active = hs_q;

   a_latch_frozen: assert property (@(posedge clk) disable iff (rst)
      hs_q |=> $stable(latch_q))
      else $error("latch changed during handshake");
   a_flags_exclusive: assert property (@(posedge clk) disable iff (rst)
      !(uflag_q == 1'b0 && lflag_q == 1'b0))
      else $error("both byte flags low");
   a_upper_load: assert property (@(posedge clk) disable iff (rst)
      (st_q == AROP_WAIT_UP && peer_ready_request)
      |=> !uflag_q && !load_pulse_n)
      else $error("upper byte not loaded");
   a_lower_load: assert property (@(posedge clk) disable iff (rst)
      (st_q == AROP_WAIT_LO && peer_ready_request)
      |=> !lflag_q && uflag_q && !load_pulse_n)
      else $error("lower byte not loaded");
   a_cs_high_z: assert property (@(posedge clk) disable iff (rst)
      (chip_select_n && !hs_q) |=> oe_q == 16'h0000 || hs_q)
      else $error("bus driven without select");
   a_full_word: assert property (@(posedge clk) disable iff (rst)
      (!chip_select_n && !upper_byte_output_en_n && !lower_byte_output_en_n
      && !hs_q) |=> oe_q == 16'hffff)
      else $error("wide read not driven");
   a_strobe_update: assert property (@(posedge clk) disable iff (rst)
      (conv_done && !hs_q) |=> ##[0:1] !result_update_strobe_n)
      else $error("no strobe on update");
   a_release_end: assert property (@(posedge clk) disable iff (rst)
      (st_q == AROP_LOAD_LO && !load_busy)
      |=> lflag_q && !hs_q)
      else $error("handshake not released");

   // Receiver latches at the first low cycle, so the byte must be there
   sequence s_upper_shown;
      data_out[7:0] == latch_q[15:8] && data_oe == 16'hffff;
   endsequence
   sequence s_lower_shown;
      data_out[7:0] == latch_q[7:0] && data_oe == 16'hffff;
   endsequence
   a_upper_valid: assert property (@(posedge clk) disable iff (rst)
      ($fell(load_pulse_n) && !uflag_q) |-> s_upper_shown)
      else $error("upper byte not on lines at load");
   a_lower_valid: assert property (@(posedge clk) disable iff (rst)
      ($fell(load_pulse_n) && !lflag_q) |-> s_lower_shown)
      else $error("lower byte not on lines at load");
   a_held_select: assert property (@(posedge clk) disable iff (rst)
      (st_q == AROP_IDLE && output_protocol_select && sel_q && !pend_q)
      |=> !hs_q)
      else $error("handshake entered without new result");
endmodule : arop_port

// *** verif/arop_peer.sv ***
// Peer model: byte receiver that requests, loads and pauses
`timescale 1ns/100ps
module arop_peer (
   input wire logic clk,
   input wire logic rst,
   input wire logic load_pulse_n,
   input wire logic upper_byte_flag_n,
   input wire logic [15:0] data_out,
   input wire logic [7:0] gap,
   output logic peer_ready_request,
   output logic [15:0] got,
   output int nbytes
);
   logic [7:0] wait_q;
   logic load_q;
   always_ff @(posedge clk) begin
      load_q <= rst | load_pulse_n;
      if (rst) begin
         peer_ready_request <= 1'b0;
         wait_q <= 8'h00;
         nbytes <= 0;
         got <= 16'h0000;
      end else if (!load_pulse_n && load_q) begin
         // Busy after each load, so drop the request
         peer_ready_request <= 1'b0;
         wait_q <= gap;
         nbytes <= nbytes + 1;
         // Flag picks the half
         if (!upper_byte_flag_n) got[15:8] <= data_out[15:8];
         else got[7:0] <= data_out[7:0];
      end else if (wait_q != 8'h00) begin
         wait_q <= wait_q - 8'h01;
      end else begin
         peer_ready_request <= 1'b1;
      end
   end
endmodule : arop_peer

// *** verif/test_adc_result_output_port.sv ***
// Testbench for the converter result output port
`timescale 1ns/100ps
module test_adc_result_output_port;
   import arop_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [14:0] res = 15'h0000;
   logic sign_bit = 1'b0;
   logic done = 1'b0;
   logic cs_n = 1'b1;
   logic ue_n = 1'b1;
   logic le_n = 1'b1;
   logic sel = 1'b0;
   logic [7:0] gap = 8'h00;
   logic upd_seen = 1'b0;
   logic req, strb_n, load_n, uf_n, lf_n, hs;
   logic [15:0] dout, doe, got, at_rise;
   int nbytes;
   int mismatches = 0;
   int total_checks = 0;
   always #5 clk = ~clk;
   always @(posedge strb_n) begin
      at_rise = dout;
      upd_seen = 1'b1;
   end
   arop_port dut_u (.clk(clk), .rst(rst), .conv_result(res),
      .conv_sign(sign_bit), .conv_done(done), .chip_select_n(cs_n),
      .upper_byte_output_en_n(ue_n), .lower_byte_output_en_n(le_n),
      .output_protocol_select(sel), .peer_ready_request(req),
      .data_out(dout), .data_oe(doe), .result_update_strobe_n(strb_n),
      .load_pulse_n(load_n), .upper_byte_flag_n(uf_n),
      .lower_byte_flag_n(lf_n), .handshake_active(hs));
   arop_peer peer_u (.clk(clk), .rst(rst), .load_pulse_n(load_n),
      .upper_byte_flag_n(uf_n), .data_out(dout), .gap(gap),
      .peer_ready_request(req), .got(got), .nbytes(nbytes));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic wait_n(input int k, input logic h);
      int n;
      n = 0;
      while (!(nbytes >= k && hs === h)) begin
         @(posedge clk);
         #1;
         n++;
         if (n > 500) begin
            mismatches++;
            report_and_stop();
         end
      end
   endtask : wait_n
   task automatic convert(input logic [15:0] v, input logic s);
      @(posedge clk);
      {sign_bit, res} <= v;
      done <= 1'b1;
      sel <= s;
      @(posedge clk);
      done <= 1'b0;
   endtask : convert
   task automatic t_bus();
      int n;
      logic [15:0] oe;
      convert(16'hA53C, 1'b0);
      n = 0;
      #1;
      repeat (30) begin
         if (strb_n === 1'b0) n++;
         @(posedge clk);
         #1;
      end
      chk(16'(n), 16'(STROBE_CYC));
      chk(at_rise, 16'hA53C);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         {cs_n, ue_n, le_n} <= i[2:0];
         @(posedge clk);
         #1;
         oe = i[2] ? 16'h0000 : {{8{~i[1]}}, {8{~i[0]}}};
         chk(doe, oe);
         chk(dout & oe, 16'hA53C & oe);
      end
      $display("bus test done");
   endtask : t_bus
   task automatic t_output_protocol_select();
      int b;
      b = nbytes;
      @(posedge clk);
      sel <= 1'b1;
      gap <= 8'h14;
      @(posedge clk);
      sel <= 1'b0;
      wait_n(b, 1'b1);
      convert(16'h7FFF, 1'b1);
      @(posedge clk);
      sel <= 1'b0;
      wait_n(b + 1, 1'b1);
      repeat (15) @(posedge clk);
      #1;
      chk(16'({hs, lf_n}), 16'h0003);
      wait_n(b + 2, 1'b0);
      chk(got, 16'hA53C);
      chk(16'({uf_n, lf_n, load_n}), 16'h0007);
      repeat (40) @(posedge clk);
      #1;
      chk(16'(nbytes - b), 16'h0002);
      cs_n <= 1'b0;
      ue_n <= 1'b0;
      le_n <= 1'b0;
      @(posedge clk);
      #1;
      chk(dout, 16'hA53C);
      cs_n <= 1'b1;
      $display("handshake test done");
   endtask : t_output_protocol_select
   task automatic t_cont();
      int b;
      logic [15:0] v [2] = '{16'h0001, 16'hFF80};
      gap <= 8'h00;
      for (int i = 0; i < 2; i++) begin
         b = nbytes;
         convert(v[i], 1'b1);
         wait_n(b + 2, 1'b0);
         chk(got, v[i]);
      end
      @(posedge clk);
      sel <= 1'b0;
      $display("continuous test done");
   endtask : t_cont
   task automatic rd_byte(input logic up, output logic [7:0] b);
      @(posedge clk);
      cs_n <= 1'b0;
      ue_n <= !up;
      le_n <= up;
      @(posedge clk);
      #1;
      chk(doe, up ? 16'hff00 : 16'h00ff);
      b = up ? dout[15:8] : dout[7:0];
      @(posedge clk);
      cs_n <= 1'b1;
   endtask : rd_byte
   // Reader: first byte clears the flag, flag looked at last
   task automatic t_integrity(input logic [15:0] old_v, input logic mid);
      logic [7:0] hi;
      logic [7:0] lo;
      rd_byte(1'b1, hi);
      upd_seen = 1'b0;
      if (mid) begin
         convert(16'h1234, 1'b0);
         repeat (12) @(posedge clk);
      end
      rd_byte(1'b0, lo);
      chk(16'(upd_seen), 16'(mid));
      chk({hi, lo}, mid ? {old_v[15:8], 8'h34} : old_v);
      $display("integrity test done");
   endtask : t_integrity
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_bus();
      t_output_protocol_select();
      t_cont();
      t_integrity(16'hff80, 1'b0);
      t_integrity(16'hff80, 1'b1);
      report_and_stop();
   end
endmodule : test_adc_result_output_port
